// ---- include/dmcd_pkg.sv ----
// shared constants and types for the display mode command decoder
package dmcd_pkg;

   // command codes, low eight data lines only
   localparam logic [7:0]  CMD_ENTER_PARTIAL = 8'h12;
   localparam logic [7:0]  CMD_ENTER_NORMAL  = 8'h13;
   localparam logic [7:0]  CMD_EXIT_INVERT   = 8'h20;
   localparam logic [7:0]  CMD_ENTER_INVERT  = 8'h21;
   localparam logic [7:0]  CMD_DISPLAY_OFF   = 8'h28;
   localparam logic [7:0]  CMD_SCROLL_AREA   = 8'h33;

   // widths
   localparam int          DATA_W   = 18;       // full parallel data bus
   localparam int          CMD_W    = 8;        // command byte
   localparam int          CNT_W    = 16;       // redundant command counter

   // apb register byte offsets
   localparam logic [11:0] OFF_STATUS = 12'h000;
   localparam logic [11:0] OFF_CTRL   = 12'h004;
   localparam logic [11:0] OFF_CMD    = 12'h008;
   localparam logic [11:0] OFF_COUNT  = 12'h00c;

   // status word bit positions
   localparam int          ST_PARTIAL = 0;
   localparam int          ST_SCROLL  = 1;
   localparam int          ST_INVERT  = 2;
   localparam int          ST_DISPLAY = 3;
   localparam int          ST_NORMAL  = 4;

   // control word bit positions, both write-one pulses
   localparam int          CTRL_SWRST  = 0;
   localparam int          CTRL_DISPON = 1;

   // host pin bundle as it arrives at the pads
   typedef struct packed {
      logic              dataCommandSel;
      logic              readStrobeN;
      logic              writeStrobeN;
      logic [DATA_W-1:0] dataLines;
   } dmcd_host_s;

   // the part of the bundle that is synchronised
   typedef struct packed {
      logic             dataCommandSel;
      logic             readStrobeN;
      logic             writeStrobeN;
      logic [CMD_W-1:0] cmdByte;
   } dmcd_sync_s;

   // idle bus: strobes high, command select low
   localparam dmcd_sync_s SYNC_RESET = '{1'b0, 1'b1, 1'b1, 8'h00};

   // display state flags
   typedef struct packed {
      logic partial;
      logic scroll;
      logic invert;
      logic display;
   } dmcd_flags_s;

   // defaults after power-on and either reset
   localparam dmcd_flags_s FLAGS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

   // apb slave states
   typedef enum logic [1:0] {
      APB_IDLE   = 2'b00,
      APB_ACCESS = 2'b01
   } dmcd_apb_e;

endpackage : dmcd_pkg

// ---- hdl/dmcd_top.sv ----
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
// Operation
// R1 - command taken on write rise, select low
// R2 - code 13h enters normal display state
// R3 - normal state clears partial and scroll
// R4 - host supplies sync two frames before
// R5 - 13h in normal state changes nothing
// R6 - resets leave normal, partial/scroll off
// R7 - 20h stops inversion, nothing else changes
// R8 - 20h without inversion has no effect
// R9 - 21h inverts panel data, default off
// R10 - 21h while inverting has no effect
// R11 - 28h blanks panel, default display off
// R12 - 28h while off has no effect
// R13 - all commands accepted in every state
// R14 - 12h enters partial, 13h leaves
// R15 - separate flag registers, reset together
module dmcd_top
#(
   parameter int PIX_W = dmcd_pkg::DATA_W      // pixel width toward panel
)
(
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       nrst,
   // apb slave
   input  wire logic [11:0]                paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // parallel host command pins
   input  wire dmcd_pkg::dmcd_host_s       hostBus,
   // pixel stream toward the panel
   input  wire logic [PIX_W-1:0]           pixelIn,
   input  wire logic                       pixelValidIn,
   output logic      [PIX_W-1:0]           panelPixel,
   output logic                            panelPixelValid,
   // display state
   output dmcd_pkg::dmcd_flags_s           modeFlags,
   output logic                            normalMode,
   output logic                            cmdStrobe
);
   import dmcd_pkg::*;

   // three-stage synchroniser on select, strobes and low data byte
   dmcd_sync_s           syncIn;         // pin values of interest
   dmcd_sync_s           s1_q;           // first stage, read only by s2
   dmcd_sync_s           s2_q;           // second stage
   dmcd_sync_s           s3_q;           // third stage
   dmcd_sync_s           filt_q;         // last agreed value
   dmcd_sync_s           filt_d;         // agreed value this cycle
   wire  [$bits(dmcd_sync_s)-1:0] agree; // s2 and s3 match per bit

   // upper data lines are ignored, only the low byte travels on [R1]
   assign syncIn = '{hostBus.dataCommandSel, hostBus.readStrobeN,
                     hostBus.writeStrobeN, hostBus.dataLines[CMD_W-1:0]};
   assign agree  = ~(s2_q ^ s3_q);
   assign filt_d = (agree & s3_q) | (~agree & filt_q);

   // synchroniser chain; strobes idle high out of reset
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         s1_q   <= SYNC_RESET;
         s2_q   <= SYNC_RESET;
         s3_q   <= SYNC_RESET;
         filt_q <= SYNC_RESET;
      end
      else
      begin
         s1_q   <= syncIn;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
      end
   end

   // write strobe rise with select low and read strobe high [R1]
   wire              wrRise  = filt_d.writeStrobeN & ~filt_q.writeStrobeN;
   wire              pinCmd  = wrRise & ~filt_d.dataCommandSel & filt_d.readStrobeN;
   wire  [CMD_W-1:0] pinCode = filt_d.cmdByte;

   // apb side state
   dmcd_apb_e        state_q;        // slave phase
   logic             apbPend_q;      // software command waiting
   logic [CMD_W-1:0] apbCode_q;      // software command code
   logic [CMD_W-1:0] lastCmd_q;      // last command applied
   logic [CNT_W-1:0] redund_q;       // count of known commands with no effect
   dmcd_flags_s      flags_q;        // separate state flags [R15]
   dmcd_flags_s      flags_d;        // next flag value
   dmcd_flags_s      cmdFlags;       // flags after command alone
   logic             normal_q;       // normal display state
   logic [31:0]      prdata_q;       // read data, held in access phase
   logic             pready_q;       // access phase answer
   logic             pslverr_q;      // unmapped address
   logic             cmdStrobe_q;    // one pulse per applied command
   logic [PIX_W-1:0] pixel_q;        // panel pixel
   logic             pixValid_q;     // panel pixel valid

   // address decode
   wire selStatus = (paddr == OFF_STATUS);
   wire selCtrl   = (paddr == OFF_CTRL);
   wire selCmd    = (paddr == OFF_CMD);
   wire selCount  = (paddr == OFF_COUNT);
   wire mapped    = selStatus | selCtrl | selCmd | selCount;

   // a write commits only at the edge that completes the access
   wire apbDone   = (state_q == APB_ACCESS) & psel & penable & pready_q;
   wire apbWrite  = apbDone & pwrite;
   wire swReset   = apbWrite & selCtrl & pwdata[CTRL_SWRST];
   wire dispOnWr  = apbWrite & selCtrl & pwdata[CTRL_DISPON];
   wire cmdWrite  = apbWrite & selCmd;

   // pin command wins; a software command waits one more cycle
   wire             cmdValid = pinCmd | apbPend_q;
   wire [CMD_W-1:0] cmdCode  = pinCmd ? pinCode : apbCode_q;

   // status word from live flags
   wire [31:0] statusWord = (32'(flags_q.partial) << ST_PARTIAL)
                          | (32'(flags_q.scroll)  << ST_SCROLL)
                          | (32'(flags_q.invert)  << ST_INVERT)
                          | (32'(flags_q.display) << ST_DISPLAY)
                          | (32'(normal_q)        << ST_NORMAL);

   // read mux; unmapped reads return zero
   wire [31:0] rdMux = selStatus ? statusWord
                     : selCmd    ? 32'(lastCmd_q)
                     : selCount  ? 32'(redund_q)
                     : 32'h0000_0000;

   // effect of one command on the flags; no power state gates it [R13]
   always_comb
   begin
      cmdFlags = flags_q;
      if (cmdValid)
      begin
         case (cmdCode)
            // leave partial and scroll; already normal stays as is [R2] [R3] [R5]
            CMD_ENTER_NORMAL:
            begin
               cmdFlags.partial = 1'b0;
               cmdFlags.scroll  = 1'b0;
            end
            // partial area display on [R14]
            CMD_ENTER_PARTIAL: cmdFlags.partial = 1'b1;
            // scroll area defined, scroll function on
            CMD_SCROLL_AREA:   cmdFlags.scroll  = 1'b1;
            // inversion off, repeat harmless [R7] [R8]
            CMD_EXIT_INVERT:   cmdFlags.invert  = 1'b0;
            // inversion on, repeat harmless [R9] [R10]
            CMD_ENTER_INVERT:  cmdFlags.invert  = 1'b1;
            // panel blank, repeat harmless [R11] [R12]
            CMD_DISPLAY_OFF:   cmdFlags.display = 1'b0;
            // unknown codes leave state alone
            default:           cmdFlags = flags_q;
         endcase
      end
   end

   // next flags: software reset overrides, display-on write yields to a display-off command
   always_comb
   begin
      flags_d = cmdFlags;
      if (dispOnWr && !(cmdValid && cmdCode == CMD_DISPLAY_OFF))
         flags_d.display = 1'b1;
      if (swReset)
         flags_d = FLAGS_RESET;    // [R6]
   end

   // known command that changed nothing
   wire knownCode = (cmdCode == CMD_ENTER_NORMAL) | (cmdCode == CMD_ENTER_PARTIAL)
                  | (cmdCode == CMD_SCROLL_AREA)  | (cmdCode == CMD_EXIT_INVERT)
                  | (cmdCode == CMD_ENTER_INVERT) | (cmdCode == CMD_DISPLAY_OFF);
   wire redundant = cmdValid & knownCode & (cmdFlags == flags_q);

   // flag registers, reset all together [R15] [R6]
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         flags_q  <= FLAGS_RESET;
         normal_q <= 1'b1;
      end
      else
      begin
         flags_q  <= flags_d;
         normal_q <= ~(flags_d.partial | flags_d.scroll);  // [R3]
      end
   end

   // command bookkeeping; a new software write wins over the apply
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         apbPend_q   <= 1'b0;
         apbCode_q   <= '0;
         lastCmd_q   <= '0;
         redund_q    <= '0;
         cmdStrobe_q <= 1'b0;
      end
      else
      begin
         apbPend_q   <= cmdWrite | (apbPend_q & pinCmd);
         apbCode_q   <= cmdWrite ? pwdata[CMD_W-1:0] : apbCode_q;
         lastCmd_q   <= cmdValid ? cmdCode : lastCmd_q;
         redund_q    <= redund_q + CNT_W'(redundant);
         cmdStrobe_q <= cmdValid;  // [R1]
      end
   end

   // pixel path: inverted only on the way out, blank while off [R9] [R11]
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         pixel_q    <= '0;
         pixValid_q <= 1'b0;
      end
      else
      begin
         pixel_q    <= !flags_q.display ? '0 : flags_q.invert ? ~pixelIn : pixelIn;
         pixValid_q <= pixelValidIn;
      end
   end

   // apb slave: setup edge loads the answer, access edge releases it
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         state_q   <= APB_IDLE;
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            // setup cycle seen
            APB_IDLE:
            begin
               if (psel && !penable)
               begin
                  state_q   <= APB_ACCESS;
                  prdata_q  <= pwrite ? 32'h0000_0000 : rdMux;
                  pready_q  <= 1'b1;
                  pslverr_q <= ~mapped;
               end
            end
            // answer stands until taken
            APB_ACCESS:
            begin
               if (apbDone)
               begin
                  state_q   <= APB_IDLE;
                  prdata_q  <= '0;
                  pready_q  <= 1'b0;
                  pslverr_q <= 1'b0;
               end
            end
            default: state_q <= APB_IDLE;
         endcase
      end
   end

   // outputs straight from flops
   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign panelPixel      = pixel_q;
   assign panelPixelValid = pixValid_q;
   assign modeFlags       = flags_q;
   assign normalMode      = normal_q;
   assign cmdStrobe       = cmdStrobe_q;

   // checks on the command behaviour
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   // a command alone, with no software override in the same cycle
   wire cmdOnly = cmdValid & ~swReset & ~dispOnWr;

   // steps are named once as sequences; only sPanelBlank spans two cycles, only sOffCmd is shared
   sequence sOffCmd;
      cmdOnly && cmdCode == CMD_DISPLAY_OFF;
   endsequence

   sequence sPanelBlank;
      !flags_q.display ##1 panelPixel == '0;
   endsequence

   sequence sInvertLive;
      flags_q.invert && flags_q.display && pixelValidIn;
   endsequence

   capture_cmd_a: assert property (pinCmd |=> cmdStrobe && lastCmd_q == $past(pinCode, 1)) // [R1]
      else $error("pin command not captured");
   normal_clear_a: assert property (cmdOnly && cmdCode == CMD_ENTER_NORMAL // [R2] [R3]
      |=> !flags_q.partial && !flags_q.scroll && normalMode)
      else $error("normal command left partial or scroll on");
   normal_noop_a: assert property (cmdOnly && cmdCode == CMD_ENTER_NORMAL && normal_q // [R5]
      |=> $stable(flags_q) && normalMode)
      else $error("normal command in normal state changed state");
   reset_default_a: assert property (@(posedge clock) disable iff (1'b0) // [R6]
      !nrst |=> flags_q == FLAGS_RESET && normalMode)
      else $error("reset defaults wrong");
   // software reset must land the same defaults as the pin reset
   sw_reset_a: assert property (swReset |=> flags_q == FLAGS_RESET && normalMode) // [R6] [R15]
      else $error("software reset defaults wrong");
   inv_exit_a: assert property (cmdOnly && cmdCode == CMD_EXIT_INVERT // [R7]
      |=> !flags_q.invert && $stable(flags_q.display) && $stable(flags_q.partial))
      else $error("exit inversion wrong");
   inv_exit_noop_a: assert property (cmdOnly && cmdCode == CMD_EXIT_INVERT && !flags_q.invert // [R8]
      |=> $stable(flags_q))
      else $error("exit inversion without inversion changed state");
   inv_enter_a: assert property (cmdOnly && cmdCode == CMD_ENTER_INVERT // [R9]
      |=> flags_q.invert && $stable(flags_q.display))
      else $error("enter inversion wrong");
   inv_pixel_a: assert property (sInvertLive |=> panelPixel == ~$past(pixelIn, 1)) // [R9]
      else $error("panel pixel not inverted");
   inv_enter_noop_a: assert property (cmdOnly && cmdCode == CMD_ENTER_INVERT && flags_q.invert // [R10]
      |=> $stable(flags_q))
      else $error("enter inversion while inverting changed state");
   disp_off_a: assert property (sOffCmd |=> sPanelBlank) // [R11]
      else $error("display off did not blank the panel");
   disp_off_noop_a: assert property (sOffCmd and !flags_q.display |=> $stable(flags_q)) // [R12]
      else $error("display off while off changed state");
   partial_enter_a: assert property (cmdOnly && cmdCode == CMD_ENTER_PARTIAL // [R14]
      |=> flags_q.partial && !normalMode)
      else $error("partial command did not leave normal state");
   // partial is left only through the normal command or a reset
   partial_keep_a: assert property (flags_q.partial && !swReset // [R14]
      && !(cmdValid && cmdCode == CMD_ENTER_NORMAL) |=> flags_q.partial)
      else $error("partial state left without the normal command");

endmodule : dmcd_top

// ---- tb/dmcd_host_model.sv ----
`timescale 1ns/1ps
// host processor on the parallel command pins
module dmcd_host_model
(
   // clock
   input  wire logic            clock,
   // pins toward the device
   output dmcd_pkg::dmcd_host_s hostBus
);
   import dmcd_pkg::*;

   // idle bus: strobes high, command select low
   initial hostBus = '{1'b0, 1'b1, 1'b1, 18'h00000};

   // one byte; strobe low 4 cycles, then high, data held 4 cycles past the rise
   // line and frame sync are not pins of this block, so the lead-in before 13h is out of view
   // partial is only left by sending 13h or by a reset, never by any other code
   task send(input logic [7:0] code, input logic sel, input logic rd, input logic [9:0] up);
      @(posedge clock);
      hostBus.dataCommandSel <= sel;
      hostBus.readStrobeN    <= rd;
      hostBus.dataLines      <= {up, code};
      hostBus.writeStrobeN   <= 1'b0;
      repeat (4) @(posedge clock);
      // rising strobe marks the byte
      hostBus.writeStrobeN   <= 1'b1;
      repeat (4) @(posedge clock);
      // hold time over: inverse data so a stale byte can never match
      hostBus.dataLines      <= ~{up, code};
      hostBus.dataCommandSel <= 1'b0;
      hostBus.readStrobeN    <= 1'b1;
      repeat (4) @(posedge clock);
   endtask : send
endmodule : dmcd_host_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
// self-checking bench for the display mode command decoder
module testbench;
   import dmcd_pkg::*;

   // clock, reset and apb master side
   logic                clock, nrst, psel, penable, pwrite, pready, pslverr;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata;
   // pins, pixels and state outputs
   dmcd_host_s          hostBus;
   logic [DATA_W-1:0]   pix, panelPixel;
   logic                pixValid, panelPixelValid, normalMode, cmdStrobe;
   dmcd_flags_s         modeFlags, expF;
   // bookkeeping
   int                  err_count, check_count, cycles, strobeCnt;

   // device under test
   dmcd_top i_dut (.clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hostBus(hostBus), .pixelIn(pix), .pixelValidIn(pixValid), .panelPixel(panelPixel),
      .panelPixelValid(panelPixelValid), .modeFlags(modeFlags), .normalMode(normalMode),
      .cmdStrobe(cmdStrobe));

   // host on the command pins
   dmcd_host_model i_host (.clock(clock), .hostBus(hostBus));

   // 125 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // cycle ceiling against hangs, and a count of command pulses
   always @(posedge clock)
   begin
      cycles++;
      if (cmdStrobe === 1'b1)
         strobeCnt++;
      if (cycles == 6000)
      begin
         err_count++;
         wrap_up();
      end
   end

   // one comparison, counted
   task chk(input logic [31:0] got, input logic [31:0] want, input string m);
      check_count++;
      if (got !== want)
      begin
         $display("Error %0t: %s got %h want %h", $time, m, got, want);
         err_count++;
      end
   endtask : chk

   // apb transfer; request held until pready is seen high
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      @(posedge clock);
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1);
      chk(n, 1, "pready wait");
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // status word, flag outputs and panel pixel against the expected flags
   task check_state;
      logic [31:0] st, r, px;
      logic        e;
      st = '0;
      st[ST_PARTIAL] = expF.partial;
      st[ST_SCROLL]  = expF.scroll;
      st[ST_INVERT]  = expF.invert;
      st[ST_DISPLAY] = expF.display;
      st[ST_NORMAL]  = !expF.partial && !expF.scroll;
      // invert at pixel width so the upper word stays zero
      px = expF.invert ? 32'(pix ^ {DATA_W{1'b1}}) : 32'(pix);
      apb(OFF_STATUS, 1'b0, 32'h0, r, e);
      chk(r, st, "status");
      chk(32'(modeFlags), 32'(expF), "flags");
      chk(32'(normalMode), 32'(st[ST_NORMAL]), "normal");
      chk(32'(panelPixel), expF.display ? px : 32'h0, "pixel");
      chk(32'(panelPixelValid), 1, "pixel valid");
   endtask : check_state

   // one command by pin or apb; expectation from the flag rules, redundancy counted
   task run_cmd(input logic [7:0] code, input logic viaPin, input logic sel, input logic rd, input logic [9:0] up);
      logic [31:0] c0, c1, r;
      logic        e, known, apply, red;
      int          s0;
      dmcd_flags_s nxt;
      apb(OFF_COUNT, 1'b0, 32'h0, c0, e);
      s0 = strobeCnt;
      if (viaPin)
         i_host.send(code, sel, rd, up);
      else
         apb(OFF_CMD, 1'b1, {24'h0, code}, r, e);
      nxt = expF;
      known = 1'b1;
      case (code)
         CMD_ENTER_PARTIAL: nxt.partial = 1'b1;
         CMD_ENTER_NORMAL:  nxt = '{1'b0, 1'b0, expF.invert, expF.display};
         CMD_EXIT_INVERT:   nxt.invert = 1'b0;
         CMD_ENTER_INVERT:  nxt.invert = 1'b1;
         CMD_DISPLAY_OFF:   nxt.display = 1'b0;
         CMD_SCROLL_AREA:   nxt.scroll = 1'b1;
         default:           known = 1'b0;
      endcase
      // only select low with read strobe idle is a command
      apply = !viaPin || (!sel && rd);
      red = apply && known && (nxt == expF);
      if (apply)
         expF = nxt;
      apb(OFF_COUNT, 1'b0, 32'h0, c1, e);
      chk(c1 - c0, 32'(red), "redundant count");
      chk(32'(strobeCnt - s0), 32'(apply), "command pulse");
      if (apply)
      begin
         apb(OFF_CMD, 1'b0, 32'h0, r, e);
         chk(r, {24'h0, code}, "last command");
      end
      check_state();
   endtask : run_cmd

   // hardware reset in mid-run
   task hw_reset;
      @(posedge clock);
      nrst <= 1'b0;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      expF = FLAGS_RESET;
      check_state();
   endtask : hw_reset

   // counts, verdict, end of run
   task wrap_up;
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // power-on defaults once reset lets go
   task power_on;
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      check_state();
   endtask : power_on

   // unmapped read errors, status is read-only, display-on write lights the panel
   task reg_access;
      logic [31:0] r;
      logic        e;
      apb(12'h010, 1'b0, 32'h0, r, e);
      chk(r, 32'h0, "unmapped read data");
      chk(32'(e), 1, "unmapped read error");
      apb(OFF_STATUS, 1'b1, 32'h1f, r, e);
      chk(32'(e), 0, "status write");
      apb(OFF_CTRL, 1'b1, 32'h1 << CTRL_DISPON, r, e);
      expF.display = 1'b1;
      check_state();
   endtask : reg_access

   // inversion on, repeated, off by software, off again with upper lines busy
   task invert_cmds;
      run_cmd(8'h21, 1'b1, 1'b0, 1'b1, 10'h3ff);
      run_cmd(8'h21, 1'b1, 1'b0, 1'b1, 10'h000);
      run_cmd(8'h20, 1'b0, 1'b0, 1'b1, 10'h000);
      run_cmd(8'h20, 1'b1, 1'b0, 1'b1, 10'h155);
   endtask : invert_cmds

   // parameter writes and a busy read strobe apply nothing; an unknown code only pulses
   task strobe_qual;
      run_cmd(8'h21, 1'b1, 1'b1, 1'b1, 10'h000);
      run_cmd(8'h21, 1'b1, 1'b0, 1'b0, 10'h000);
      run_cmd(8'h11, 1'b1, 1'b0, 1'b1, 10'h000);
   endtask : strobe_qual

   // partial on, inversion inside partial, scroll, back to normal twice
   task partial_normal;
      run_cmd(8'h12, 1'b1, 1'b0, 1'b1, 10'h000);
      run_cmd(8'h21, 1'b1, 1'b0, 1'b1, 10'h000);
      run_cmd(8'h33, 1'b0, 1'b0, 1'b1, 10'h000);
      run_cmd(8'h13, 1'b1, 1'b0, 1'b1, 10'h000);
      run_cmd(8'h13, 1'b1, 1'b0, 1'b1, 10'h000);
   endtask : partial_normal

   // display off by pin, again by software, then partial while dark
   task display_off;
      run_cmd(8'h28, 1'b1, 1'b0, 1'b1, 10'h000);
      run_cmd(8'h28, 1'b0, 1'b0, 1'b1, 10'h000);
      run_cmd(8'h12, 1'b0, 1'b0, 1'b1, 10'h000);
   endtask : display_off

   // software reset back to defaults, then commands still apply
   task sw_reset;
      logic [31:0] r;
      logic        e;
      apb(OFF_CTRL, 1'b1, 32'h1 << CTRL_SWRST, r, e);
      expF = FLAGS_RESET;
      check_state();
      run_cmd(8'h12, 1'b1, 1'b0, 1'b1, 10'h000);
      run_cmd(8'h21, 1'b0, 1'b0, 1'b1, 10'h000);
   endtask : sw_reset

   // main sequence
   initial
   begin
      {nrst, psel, penable, pwrite, paddr, pwdata} <= '0;
      pix      <= 18'h2a5c3;
      pixValid <= 1'b1;
      expF      = FLAGS_RESET;
      power_on();
      reg_access();
      invert_cmds();
      strobe_qual();
      partial_normal();
      display_off();
      sw_reset();
      hw_reset();
      wrap_up();
   end
endmodule : testbench
